// ### ecc_memory_healer_pkg.sv
// package: constants and carriers for the ecc memory healer
package ecc_memory_healer_pkg;
	localparam int DATA_W = 32;
	localparam int CHECK_W = 7;
	localparam int CODE_W = DATA_W + CHECK_W;
	localparam int PHYS_AW = 16;
	localparam int BLOCK_AW = 12;
	localparam int NUM_BLOCKS = 16;
	localparam int HEAL_SLOTS = 32;
	localparam int HEAL_IDX_W = 5;
	localparam int LOG_BLK_W = 8;
	localparam logic [CODE_W-1:0] PAT_A = 39'h55_5555_5555;
	localparam logic [CODE_W-1:0] PAT_B = 39'h2A_AAAA_AAAA;
	localparam logic [CODE_W-1:0] INJECT_MASK = 39'h00_0000_0003;
	localparam logic [PHYS_AW-1:0] INJECT_ADDR = 16'h0000;
	localparam logic [NUM_BLOCKS-1:0] MAP_RESET = 16'h0000;

	typedef enum logic [2:0]
	{
		ST_SELF = 3'h0,
		ST_WRITE = 3'h1,
		ST_READ = 3'h2,
		ST_INJECT = 3'h3,
		ST_RUN = 3'h4
	} phase_type;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [LOG_BLK_W+BLOCK_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_type;

	typedef struct packed
	{
		logic valid;
		logic corrected;
		logic uncorrectable;
		logic [DATA_W-1:0] rdata;
		logic [PHYS_AW-1:0] failAddr;
	} bus_rsp_type;

	typedef struct packed
	{
		logic en;
		logic write;
		logic [PHYS_AW-1:0] addr;
		logic [CODE_W-1:0] wdata;
	} ram_cmd_type;
endpackage

// ### ecc_memory_healer.sv
// file: memory controller with secded, block mapping and healing store
// Function
// - self-test first, then write-then-read RAM pattern test
// - hold bus answers until memory test ends
// - inject double-bit error after the pattern test
// - classify memory absent, good, or hard-failed
// - flag whole 16K block suspect on fault
// - seven check bits per 32-bit word
// - map out block on power-up check failure
// - correct single-bit error, return corrected word
// - store corrected word in one of 32 slots
// - later accesses served from healing slot
// - healing redirect adds no latency
// - sixteen 16K blocks placed anywhere or disabled
// - mapped-out block answers no address
// - retest maps back unless the healing store has overflowed
module ecc_memory_healer #(
	parameter logic [7:0] CONTROLLER_ID = 8'h01, // arbitrary value
	// words tested per block are 2**TEST_OFS_W; smaller only shortens runs
	parameter int TEST_OFS_W = ecc_memory_healer_pkg::BLOCK_AW
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire ecc_memory_healer_pkg::bus_req_type busReq,
	input wire logic [ecc_memory_healer_pkg::NUM_BLOCKS-1:0] retestBlk,
	input wire logic [ecc_memory_healer_pkg::NUM_BLOCKS*
		ecc_memory_healer_pkg::LOG_BLK_W-1:0] blockBase,
	input wire logic [ecc_memory_healer_pkg::CODE_W-1:0] ramRdata,
	input wire logic ramPresent,
	output ecc_memory_healer_pkg::bus_rsp_type busRsp_q,
	output logic [7:0] controllerId_q,
	output ecc_memory_healer_pkg::ram_cmd_type ramCmd_q,
	output logic [ecc_memory_healer_pkg::NUM_BLOCKS-1:0] mapped_q,
	output logic [ecc_memory_healer_pkg::NUM_BLOCKS-1:0] suspect_q,
	output logic memAbsent_q,
	output logic hardFail_q,
	output logic testDone_q,
	output logic healOverflow_q
);
	localparam int DW = ecc_memory_healer_pkg::DATA_W;
	localparam int CW = ecc_memory_healer_pkg::CODE_W;
	localparam int AW = ecc_memory_healer_pkg::PHYS_AW;
	localparam int HS = ecc_memory_healer_pkg::HEAL_SLOTS;
	localparam int HW = ecc_memory_healer_pkg::HEAL_IDX_W;
	localparam int NB = ecc_memory_healer_pkg::NUM_BLOCKS;
	localparam int LW = ecc_memory_healer_pkg::LOG_BLK_W;
	localparam int BW = ecc_memory_healer_pkg::BLOCK_AW;
	localparam int TW = TEST_OFS_W;
	localparam logic [AW-1:0] TEST_LAST = AW'(NB * (2 ** TW) - 1);

	// physical word of a test step: block from the top bits, offset below
	function automatic logic [AW-1:0] testAddr(input logic [AW-1:0] c);
		logic [AW-1:0] a;
		a = '0;
		a[AW-1:BW] = c[TW+AW-BW-1:TW];
		a[TW-1:0] = c[TW-1:0];
		return a;
	endfunction

	// test pattern stored as a codeword, so check bits are exercised too
	function automatic logic [CW-1:0] patWord(input logic odd);
		return encode(odd ? ecc_memory_healer_pkg::PAT_B[DW-1:0]
			: ecc_memory_healer_pkg::PAT_A[DW-1:0]);
	endfunction

	// hamming position of a code bit; data fill non-power-of-two slots
	function automatic logic [5:0] codePos(input int bitIdx);
		int p;
		int d;
		p = 1;
		d = 0;
		for (int k = 1; k < 40; k++)
		begin
			if ((k & (k - 1)) != 0)
			begin
				if (d == bitIdx)
					p = k;
				d++;
			end
		end
		return 6'(p);
	endfunction

	// encode: check bits plus overall parity give secded
	function automatic logic [CW-1:0] encode(input logic [DW-1:0] d);
		logic [5:0] c;
		logic [5:0] pos;
		c = 6'h00;
		for (int i = 0; i < DW; i++)
		begin
			pos = codePos(i);
			if (d[i])
				c = c ^ pos;
		end
		return {^{d, c}, c, d};
	endfunction

	// syndrome of a stored word
	function automatic logic [6:0] syndrome(input logic [CW-1:0] w);
		logic [5:0] c;
		logic [5:0] pos;
		c = w[CW-2:DW];
		for (int i = 0; i < DW; i++)
		begin
			pos = codePos(i);
			if (w[i])
				c = c ^ pos;
		end
		return {^w, c};
	endfunction

	// correct single-bit error in data bits
	function automatic logic [DW-1:0] fixData(input logic [CW-1:0] w);
		logic [6:0] sy;
		logic [DW-1:0] d;
		sy = syndrome(w);
		d = w[DW-1:0];
		for (int i = 0; i < DW; i++)
		begin
			if (codePos(i) == sy[5:0])
				d[i] = ~d[i];
		end
		return d;
	endfunction

	ecc_memory_healer_pkg::phase_type phase_q, phase_d;
	logic [AW-1:0] cnt_q, cnt_d;
	logic [NB-1:0] mapped_d, suspect_d;
	logic absent_d, hard_d, done_d, ovf_d;
	logic pend_q, pend_d;
	logic [AW-1:0] pendAddr_q, pendAddr_d;
	logic pendWr_q, pendWr_d;
	logic [DW-1:0] pendWdata_q, pendWdata_d;
	logic [HS-1:0] healValid_q, healValid_d;
	logic [AW-1:0] healAddr_q [HS];
	logic [AW-1:0] healAddr_d [HS];
	logic [DW-1:0] healData_q [HS];
	logic [DW-1:0] healData_d [HS];
	logic [HW-1:0] healNext_q, healNext_d;
	ecc_memory_healer_pkg::bus_rsp_type rsp_d;
	ecc_memory_healer_pkg::ram_cmd_type cmd_d;
	logic [AW-1:0] hitAddr;
	logic hit;
	logic [HW-1:0] hitIdx;
	logic [6:0] syn;
	logic [DW-1:0] fixed;

	// block decode: compare logical block against each mapped base
	logic [NB-1:0] blkMatch;
	genvar g;
	generate
		for (g = 0; g < NB; g++)
		begin : g_dec
			assign blkMatch[g] = mapped_q[g] && busReq.addr[BW+LW-1:BW]
				== blockBase[g*LW +: LW];
		end
	endgenerate

	// heal lookup on the pending address, in parallel with the RAM read
	always_comb
	begin
		hit = 1'b0;
		hitIdx = '0;
		hitAddr = pendAddr_q;
		for (int i = 0; i < HS; i++)
		begin
			if (healValid_q[i] && healAddr_q[i] == hitAddr)
			begin
				hit = 1'b1;
				hitIdx = HW'(i);
			end
		end
		syn = syndrome(ramRdata);
		fixed = fixData(ramRdata);
	end

	// sequencer: self-test, pattern test, then run-time service
	always_comb
	begin
		phase_d = phase_q;
		cnt_d = cnt_q;
		mapped_d = mapped_q;
		suspect_d = suspect_q;
		absent_d = memAbsent_q;
		hard_d = hardFail_q;
		done_d = testDone_q;
		ovf_d = healOverflow_q;
		pend_d = 1'b0;
		pendAddr_d = pendAddr_q;
		pendWr_d = 1'b0;
		pendWdata_d = pendWdata_q;
		healValid_d = healValid_q;
		healAddr_d = healAddr_q;
		healData_d = healData_q;
		healNext_d = healNext_q;
		rsp_d = '0;
		rsp_d.failAddr = busRsp_q.failAddr;
		cmd_d = '0;
		case (phase_q)
			ecc_memory_healer_pkg::ST_SELF:
			begin
				// check encoder round trip internally before memory test
				if (syndrome(encode(32'hA5A5_5A5A)) == 7'h00)
					phase_d = ecc_memory_healer_pkg::ST_WRITE;
				else
					hard_d = 1'b1;
			end
			ecc_memory_healer_pkg::ST_WRITE:
			begin
				cmd_d.en = 1'b1;
				cmd_d.write = 1'b1;
				cmd_d.addr = testAddr(cnt_q);
				cmd_d.wdata = patWord(cnt_q[0]);
				cnt_d = cnt_q + 16'h0001;
				// restart the count so the read pass walks the same words
				if (cnt_q == TEST_LAST)
				begin
					cnt_d = '0;
					phase_d = ecc_memory_healer_pkg::ST_READ;
				end
			end
			ecc_memory_healer_pkg::ST_READ:
			begin
				// one-cycle RAM latency: compare data of previous address
				cmd_d.en = 1'b1;
				cmd_d.addr = testAddr(cnt_q);
				cnt_d = cnt_q + 16'h0001;
				pend_d = 1'b1;
				pendAddr_d = testAddr(cnt_q);
				if (pend_q && !ramPresent)
					absent_d = 1'b1;
				if (pend_q && (!ramPresent
					|| ramRdata != patWord(pendAddr_q[0]) || syn != 7'h00))
				begin
					hard_d = ramPresent;
					suspect_d[pendAddr_q[AW-1:BW]] = 1'b1;
				end
				if (pend_q && pendAddr_q == testAddr(TEST_LAST))
				begin
					pend_d = 1'b0;
					mapped_d = ~suspect_d;
					phase_d = ecc_memory_healer_pkg::ST_INJECT;
				end
			end
			ecc_memory_healer_pkg::ST_INJECT:
			begin
				// plant a double-bit error for the CPU to find
				cmd_d.en = 1'b1;
				cmd_d.write = 1'b1;
				cmd_d.addr = ecc_memory_healer_pkg::INJECT_ADDR;
				cmd_d.wdata = encode('0) ^ ecc_memory_healer_pkg::INJECT_MASK;
				done_d = 1'b1;
				phase_d = ecc_memory_healer_pkg::ST_RUN;
			end
			ecc_memory_healer_pkg::ST_RUN:
			begin
				// retest outcome: map back unless the healing store has overflowed
				for (int b = 0; b < NB; b++)
				begin
					if (retestBlk[b] && !mapped_q[b])
					begin
						if (!healOverflow_q)
						begin
							mapped_d[b] = 1'b1;
							suspect_d[b] = 1'b0;
						end
					end
				end
				if (busReq.valid && |blkMatch)
				begin
					cmd_d.en = 1'b1;
					cmd_d.write = busReq.write;
					for (int b = 0; b < NB; b++)
						if (blkMatch[b])
							cmd_d.addr = {4'(b), busReq.addr[BW-1:0]};
					cmd_d.wdata = encode(busReq.wdata);
					pend_d = 1'b1;
					pendWr_d = busReq.write;
					pendAddr_d = cmd_d.addr;
					pendWdata_d = busReq.wdata;
				end
				if (pend_q)
				begin
					rsp_d.valid = 1'b1;
					if (hit)
					begin
						if (pendWr_q)
							healData_d[hitIdx] = pendWdata_q;
						rsp_d.rdata = healData_q[hitIdx];
					end
					else if (!pendWr_q && syn[6])
					begin
						rsp_d.rdata = fixed;
						rsp_d.corrected = 1'b1;
						if (&healValid_q)
							ovf_d = 1'b1;
						else
						begin
							healValid_d[healNext_q] = 1'b1;
							healAddr_d[healNext_q] = pendAddr_q;
							healData_d[healNext_q] = fixed;
							healNext_d = healNext_q + 5'h01;
						end
					end
					else if (!pendWr_q && syn != 7'h00)
					begin
						rsp_d.uncorrectable = 1'b1;
						rsp_d.failAddr = pendAddr_q;
					end
					else
						rsp_d.rdata = ramRdata[DW-1:0];
				end
			end
			default:
				phase_d = ecc_memory_healer_pkg::ST_SELF;
		endcase
	end

	// registers for all state above
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase_q <= ecc_memory_healer_pkg::ST_SELF;
			cnt_q <= '0;
			mapped_q <= ecc_memory_healer_pkg::MAP_RESET;
			suspect_q <= '0;
			memAbsent_q <= 1'b0;
			hardFail_q <= 1'b0;
			testDone_q <= 1'b0;
			healOverflow_q <= 1'b0;
			pend_q <= 1'b0;
			pendAddr_q <= '0;
			pendWr_q <= 1'b0;
			pendWdata_q <= '0;
			healValid_q <= '0;
			healNext_q <= '0;
			busRsp_q <= '0;
			ramCmd_q <= '0;
			controllerId_q <= 8'h00;
			for (int i = 0; i < HS; i++)
			begin
				healAddr_q[i] <= '0;
				healData_q[i] <= '0;
			end
		end
		else
		begin
			phase_q <= phase_d;
			cnt_q <= cnt_d;
			mapped_q <= mapped_d;
			suspect_q <= suspect_d;
			memAbsent_q <= absent_d;
			hardFail_q <= hard_d;
			testDone_q <= done_d;
			healOverflow_q <= ovf_d;
			pend_q <= pend_d;
			pendAddr_q <= pendAddr_d;
			pendWr_q <= pendWr_d;
			pendWdata_q <= pendWdata_d;
			healValid_q <= healValid_d;
			healNext_q <= healNext_d;
			busRsp_q <= rsp_d;
			ramCmd_q <= cmd_d;
			controllerId_q <= CONTROLLER_ID;
			healAddr_q <= healAddr_d;
			healData_q <= healData_d;
		end
	end
endmodule

// ### ecc_memory_healer_asserts.sv
// checker: bus timing, block mapping and power-up outcome properties
module ecc_memory_healer_asserts
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire ecc_memory_healer_pkg::bus_req_type busReq,
	input wire logic [15:0] retestBlk,
	input wire logic [127:0] blockBase,
	input wire ecc_memory_healer_pkg::bus_rsp_type busRsp_q,
	input wire ecc_memory_healer_pkg::ram_cmd_type ramCmd_q,
	input wire logic [15:0] mapped_q,
	input wire logic [15:0] suspect_q,
	input wire logic memAbsent_q,
	input wire logic hardFail_q,
	input wire logic testDone_q,
	input wire logic healOverflow_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hit;
	logic [3:0] hitIdx;
	logic take;

	// which mapped block claims the logical block of the request
	always_comb
	begin
		hit = 1'b0;
		hitIdx = 4'h0;
		for (int b = 0; b < 16; b++)
			if (mapped_q[b] && blockBase[8*b+:8] == busReq.addr[19:12])
			begin
				hit = 1'b1;
				hitIdx = 4'(b);
			end
	end
	assign take = busReq.valid && testDone_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	property p_quietTest;
		busRsp_q.valid |-> testDone_q;
	endproperty
	a_quietTest: assert property (p_quietTest)
		else $error("bus answer before memory test end");
	property p_latency;
		take && hit |=> ramCmd_q.en ##1 busRsp_q.valid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("answer not two cycles after request");
	property p_cmdAddr;
		take && hit |=> ramCmd_q.addr[15:12] == $past(hitIdx)
			&& ramCmd_q.addr[11:0] == $past(busReq.addr[11:0]);
	endproperty
	a_cmdAddr: assert property (p_cmdAddr)
		else $error("physical address not from mapped block");
	property p_unmapped;
		take && !hit |=> !ramCmd_q.en ##1 !busRsp_q.valid;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address answered");
	property p_outcome;
		$rose(testDone_q) |-> mapped_q == ~suspect_q;
	endproperty
	a_outcome: assert property (p_outcome)
		else $error("suspect block left mapped");
	property p_classify;
		$rose(testDone_q) && !memAbsent_q
			|-> hardFail_q == (suspect_q != 16'h0000);
	endproperty
	a_classify: assert property (p_classify)
		else $error("hard fail flag disagrees with suspects");
	property p_failHold;
		testDone_q ##1 !(busRsp_q.valid && busRsp_q.uncorrectable)
			|-> $stable(busRsp_q.failAddr);
	endproperty
	a_failHold: assert property (p_failHold)
		else $error("fail address moved without a double error");
	property p_retest;
		testDone_q && !healOverflow_q && (retestBlk & ~mapped_q) != 16'h0000
			|-> ##[1:16] (retestBlk & ~mapped_q) == 16'h0000;
	endproperty
	a_retest: assert property (p_retest)
		else $error("retested block not mapped back");

	c_corr: cover property (busRsp_q.valid && busRsp_q.corrected);
	c_ue: cover property (busRsp_q.valid && busRsp_q.uncorrectable);
	c_back: cover property (retestBlk != 16'h0000 && mapped_q == 16'hFFFF);
endmodule

bind ecc_memory_healer ecc_memory_healer_asserts chk (.*);

// ### ram_model.sv
// partner: registered ram array with a read fault set by the bench
module ram_model
(
	input wire logic ref_clk,
	input wire ecc_memory_healer_pkg::ram_cmd_type ramCmd_q,
	input wire logic [15:0] faultAddr,
	input wire logic [38:0] faultMask,
	output logic [38:0] ramRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [38:0] mem [65536];

	// writes land at the edge that closes the command's cycle
	always @(posedge ref_clk)
	begin
		if (ramCmd_q.en && ramCmd_q.write)
			mem[ramCmd_q.addr] <= ramCmd_q.wdata;
	end

	// the command is already registered, so a read answers in its own cycle;
	// outside reads the inverse shows, so stale data never passes
	assign ramRdata = (ramCmd_q.en && !ramCmd_q.write)
		? mem[ramCmd_q.addr]
		^ (ramCmd_q.addr == faultAddr ? faultMask : 39'h00_0000_0000)
		: ~mem[ramCmd_q.addr];
endmodule

// ### testbench.sv
// testbench: power-up test, ecc, healing and block mapping scenarios
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	ecc_memory_healer_pkg::bus_req_type busReq = '0;
	ecc_memory_healer_pkg::bus_rsp_type busRsp_q, r;
	ecc_memory_healer_pkg::ram_cmd_type ramCmd_q;
	logic [15:0] retestBlk = 16'h0000;
	logic [127:0] blockBase = 128'h1F1E1D1C1B1A19181716151413121110;
	logic ramPresent = 1'b1;
	logic [15:0] faultAddr = 16'h3005;
	logic [38:0] faultMask = 39'h00_0000_0001;
	logic [38:0] ramRdata;
	logic [15:0] mapped_q, suspect_q;
	logic memAbsent_q, hardFail_q, testDone_q, healOverflow_q;
	logic [7:0] controllerId_q;
	int n_mismatch = 0;
	int checked = 0;

	// a short test span per block keeps the power-up pass brief
	ecc_memory_healer #(.TEST_OFS_W(4)) DUT (.*);
	ram_model ram (.*);

	initial
		forever #20 ref_clk = ~ref_clk;

	task automatic results;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [38:0] e, g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one request from a falling edge; the answer stands one cycle, two
	// edges after the request is taken, and is sampled while it stands
	task automatic access(input logic w, input logic [19:0] a,
		input logic [31:0] d, output ecc_memory_healer_pkg::bus_rsp_type q);
		busReq = {1'b1, w, a, d};
		@(negedge ref_clk);
		busReq.valid = 1'b0;
		@(negedge ref_clk);
		q = busRsp_q;
	endtask

	// reset, early request ignored, then the pattern test outcome
	task automatic powerUp;
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		access(1'b0, 20'h10000, 32'h0, r);
		chk("early rsp", 1'b0, r.valid);
		for (int i = 0; i < 2000 && testDone_q !== 1'b1; i++)
			@(negedge ref_clk);
		chk("testDone", 1'b1, testDone_q);
		if (testDone_q !== 1'b1)
			results();
		chk("ctrl id", 8'h01, controllerId_q);
		chk("suspect", 16'h0008, suspect_q);
		chk("mapped", 16'hFFF7, mapped_q);
		chk("hardFail", 1'b1, hardFail_q);
		chk("memAbsent", 1'b0, memAbsent_q);
	endtask

	// the double error planted after the pattern test comes back uncorrectable
	task automatic injected;
		access(1'b0, 20'h10000, 32'h0, r);
		chk("inject valid", 1'b1, r.valid);
		chk("inject ue", 1'b1, r.uncorrectable);
		chk("fail addr", 16'h0000, r.failAddr);
		access(1'b1, 20'h11010, 32'h1234ABCD, r);
		faultAddr = 16'h1010;
		faultMask = 39'h00_0000_0003;
		access(1'b0, 20'h11010, 32'h0, r);
		chk("second ue", 1'b1, r.uncorrectable);
		chk("second addr", 16'h1010, r.failAddr);
	endtask

	// single flip corrected, then the healed copy hides a double flip
	task automatic heal;
		faultAddr = 16'h2007;
		faultMask = 39'h00_0000_0020;
		access(1'b1, 20'h12007, 32'hCAFE1234, r);
		access(1'b0, 20'h12007, 32'h0, r);
		chk("corr flag", 1'b1, r.corrected);
		chk("corr data", 32'hCAFE1234, r.rdata);
		faultMask = 39'h00_0000_0003;
		access(1'b0, 20'h12007, 32'h0, r);
		chk("healed valid", 1'b1, r.valid);
		chk("healed ue", 1'b0, r.uncorrectable);
		chk("healed data", 32'hCAFE1234, r.rdata);
		access(1'b1, 20'h12007, 32'h600DF00D, r);
		access(1'b0, 20'h12007, 32'h0, r);
		chk("healed write", 32'h600DF00D, r.rdata);
		chk("overflow", 1'b0, healOverflow_q);
	endtask

	// mapped-out block stays silent until a retest maps it back
	task automatic retest;
		access(1'b0, 20'h13005, 32'h0, r);
		chk("mapped-out rsp", 1'b0, r.valid);
		retestBlk = 16'h0008;
		for (int i = 0; i < 20 && mapped_q !== 16'hFFFF; i++)
			@(negedge ref_clk);
		chk("remapped", 16'hFFFF, mapped_q);
		@(negedge ref_clk);
		retestBlk = 16'h0000;
		access(1'b0, 20'h13005, 32'h0, r);
		chk("remapped rsp", 1'b1, r.valid);
	endtask

	// moving a block's base moves its contents with it
	task automatic remap;
		access(1'b1, 20'h11020, 32'h0BAD5EED, r);
		blockBase[15:8] = 8'h80;
		access(1'b0, 20'h80020, 32'h0, r);
		chk("moved data", 32'h0BAD5EED, r.rdata);
		access(1'b0, 20'h11020, 32'h0, r);
		chk("old base rsp", 1'b0, r.valid);
	endtask

	// reset in mid-run with no RAM answering: every block is mapped out
	task automatic absent;
		@(negedge ref_clk);
		resetn = 1'b0;
		ramPresent = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk("reset mapped", 16'h0000, mapped_q);
		chk("reset done", 1'b0, testDone_q);
		resetn = 1'b1;
		for (int i = 0; i < 2000 && testDone_q !== 1'b1; i++)
			@(negedge ref_clk);
		chk("absent done", 1'b1, testDone_q);
		if (testDone_q !== 1'b1)
			results();
		chk("absent flag", 1'b1, memAbsent_q);
		chk("absent hard", 1'b0, hardFail_q);
		chk("absent suspect", 16'hFFFF, suspect_q);
		chk("absent map", 16'h0000, mapped_q);
		access(1'b0, 20'h10000, 32'h0, r);
		chk("absent rsp", 1'b0, r.valid);
	endtask

	initial
	begin
		powerUp();
		injected();
		heal();
		retest();
		remap();
		absent();
		results();
	end
endmodule
